/* src/dbrl_top.sv */
// breakpoint generation, trace alignment and request routing
`timescale 1ns/1ns
module dbrl_top (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic armed_i,
	input  wire logic trace_source_select_i,
	input  wire logic immediate_break_select_i,
	input  wire logic trace_alignment_select_i,
	input  wire logic breakpoint_request_enable_i,
	input  wire logic debug_target_i,
	input  wire logic forced_trigger_bit_i,
	input  wire logic final_state_entry_i,
	input  wire logic tag_set_i,
	input  wire logic tag_hit_i,
	input  wire logic trace_full_i,
	input  wire logic bdm_enabled_i,
	input  wire logic bdm_active_i,
	input  wire logic bdm_trace_cmd_i,
	input  wire logic software_interrupt_instr_i,
	input  wire logic background_instr_i,
	input  wire logic cpu_swi_taken_i,
	input  wire logic cpu_bdm_taken_i,
	input  wire logic monitor_serviced_i,
	output logic      swi_request_o,
	output logic      bdm_request_o,
	output logic      final_state_o,
	output logic      tracing_o,
	output logic      trace_stop_o,
	output logic      disarm_o,
	output logic      user_swi_deferred_o,
	output logic      resume_after_background_instr_o
);

	// ==========================================================
	// state
	dbrl_pkg::dbrl_regs_t q;
	dbrl_pkg::dbrl_regs_t next_q;

	logic tag_fire;
	logic forced_trigger_bit_cmp;
	logic forced_trigger_bit_soft;
	logic forced_trigger_bit;
	logic do_req;
	logic to_swi;
	logic to_bdm;
	logic swi_kill;
	logic idle;

	// ==========================================================
	// tagging
	dbrl_tag_tracker u_tag (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.tag_set_i (tag_set_i & armed_i),
		.tag_hit_i (tag_hit_i),
		.block_i   (bdm_active_i | bdm_trace_cmd_i),
		.fire_o    (tag_fire)
	);

	// ==========================================================
	// routing
	dbrl_route u_route (
		.enable_i      (breakpoint_request_enable_i),
		.target_i      (debug_target_i),
		.bdm_enabled_i (bdm_enabled_i),
		.bdm_active_i  (bdm_active_i),
		.to_swi_o      (to_swi),
		.to_bdm_o      (to_bdm)
	);

	// ==========================================================
	// trigger qualification
	always_comb begin
		idle      = (q.st == dbrl_pkg::ST_IDLE);
		forced_trigger_bit_cmp  = armed_i & ~bdm_active_i & (final_state_entry_i | tag_fire);
		forced_trigger_bit_soft = forced_trigger_bit_i;
		forced_trigger_bit      = idle & (forced_trigger_bit_cmp | forced_trigger_bit_soft);
	end

	// ==========================================================
	// next state
	always_comb begin
		next_q             = q;
		next_q.final_state = dbrl_pkg::RST_BIT;
		next_q.trace_stop  = dbrl_pkg::RST_BIT;
		next_q.disarm      = dbrl_pkg::RST_BIT;
		do_req             = 1'h0;
		swi_kill           = 1'h0;

		case (q.st)
			dbrl_pkg::ST_IDLE: begin
				if (forced_trigger_bit) begin
					next_q.final_state = 1'h1;
					next_q.src_soft    = forced_trigger_bit_soft;
					if (immediate_break_select_i) begin
						next_q.trace_stop = trace_source_select_i;
						do_req            = breakpoint_request_enable_i;
					end else if (!trace_source_select_i) begin
						do_req = breakpoint_request_enable_i;
					end else if (trace_alignment_select_i == dbrl_pkg::ALIGN_END) begin
						next_q.trace_stop = 1'h1;
						do_req            = breakpoint_request_enable_i;
						next_q.disarm     = ~breakpoint_request_enable_i;
					end else begin
						next_q.tracing = 1'h1;
						next_q.st      = dbrl_pkg::ST_TRACE;
					end
				end
			end
			dbrl_pkg::ST_TRACE: begin
				if (trace_full_i) begin
					next_q.tracing    = dbrl_pkg::RST_BIT;
					next_q.trace_stop = 1'h1;
					next_q.st         = dbrl_pkg::ST_IDLE;
					do_req            = breakpoint_request_enable_i;
					next_q.disarm     = ~breakpoint_request_enable_i;
				end
			end
			dbrl_pkg::ST_REQ: begin
				if (q.bdm_req && cpu_bdm_taken_i) begin
					next_q.bdm_req = dbrl_pkg::RST_BIT;
					next_q.st      = dbrl_pkg::ST_HOLD;
				end else if (q.swi_req && cpu_swi_taken_i) begin
					next_q.swi_req = dbrl_pkg::RST_BIT;
					next_q.st      = dbrl_pkg::ST_IDLE;
				end
			end
			dbrl_pkg::ST_HOLD: begin
				if (monitor_serviced_i) begin
					next_q.st = dbrl_pkg::ST_IDLE;
				end else if (!bdm_active_i && bdm_enabled_i) begin
					next_q.bdm_req = 1'h1;
					next_q.st      = dbrl_pkg::ST_REQ;
				end else if (!bdm_active_i) begin
					next_q.st = dbrl_pkg::ST_IDLE;
				end
			end
			default: begin
				next_q = dbrl_pkg::REGS_RST;
			end
		endcase

		if (do_req) begin
			swi_kill = next_q.src_soft & background_instr_i & bdm_enabled_i;
			next_q.bdm_req = to_bdm;
			next_q.swi_req = to_swi & ~swi_kill;
			if (to_bdm || (to_swi && !swi_kill)) begin
				next_q.st = dbrl_pkg::ST_REQ;
			end
			if (to_bdm && software_interrupt_instr_i) begin
				next_q.swi_deferred = 1'h1;
			end
			if (background_instr_i && (next_q.src_soft || tag_fire)) begin
				next_q.resume_next = 1'h1;
			end
		end

		if (q.swi_deferred && !bdm_active_i && !do_req
			&& (q.st == dbrl_pkg::ST_HOLD || q.st == dbrl_pkg::ST_IDLE)) begin
			next_q.swi_deferred = dbrl_pkg::RST_BIT;
		end
		if (q.resume_next && !do_req && !bdm_active_i && !q.bdm_req
			&& q.st != dbrl_pkg::ST_REQ) begin
			next_q.resume_next = dbrl_pkg::RST_BIT;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			q <= dbrl_pkg::REGS_RST;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	assign swi_request_o       = q.swi_req;
	assign bdm_request_o       = q.bdm_req;
	assign final_state_o       = q.final_state;
	assign tracing_o           = q.tracing;
	assign trace_stop_o        = q.trace_stop;
	assign disarm_o            = q.disarm;
	assign user_swi_deferred_o = q.swi_deferred;
	assign resume_after_background_instr_o = q.resume_next;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_begin;
		idle && forced_trigger_bit && !immediate_break_select_i && trace_source_select_i
			&& trace_alignment_select_i;
	endsequence

	sequence s_full_req;
		tracing_o && trace_full_i && breakpoint_request_enable_i
			&& (to_swi || to_bdm) && !background_instr_i;
	endsequence

	begin_trace_a: assert property (s_begin |=> tracing_o && !swi_request_o
		&& !bdm_request_o)
		else $error("begin alignment did not start tracing");

	full_request_a: assert property (s_full_req |=> (swi_request_o || bdm_request_o)
		&& !tracing_o && trace_stop_o)
		else $error("no request when trace buffer filled");

	imm_break_a: assert property (idle && forced_trigger_bit && immediate_break_select_i
		&& to_bdm |=> bdm_request_o && !tracing_o)
		else $error("immediate break not requested");

	no_trace_a: assert property (idle && forced_trigger_bit && !trace_source_select_i && to_bdm
		|=> bdm_request_o && final_state_o)
		else $error("untraced breakpoint delayed");

	end_disarm_a: assert property (idle && forced_trigger_bit && !immediate_break_select_i
		&& trace_source_select_i && !trace_alignment_select_i
		&& !breakpoint_request_enable_i
		|=> disarm_o && !swi_request_o && !bdm_request_o)
		else $error("end alignment did not disarm");

	bdm_hold_a: assert property (bdm_request_o && !cpu_bdm_taken_i
		|=> bdm_request_o)
		else $error("debug request dropped before taken");

	swi_hold_a: assert property (swi_request_o && !cpu_swi_taken_i
		|=> swi_request_o)
		else $error("interrupt request dropped before taken");

	retrig_ignore_a: assert property (tracing_o && !trace_full_i
		|=> tracing_o && !final_state_o)
		else $error("trigger during trace had effect");

	bdm_block_a: assert property (idle && bdm_active_i && !forced_trigger_bit_i
		|=> !final_state_o)
		else $error("comparator trigger while debug active");

	route_a: assert property ($rose(bdm_request_o) |->
		$past(debug_target_i) && $past(bdm_enabled_i)
		|| $past(q.st) == dbrl_pkg::ST_HOLD)
		else $error("debug request with wrong routing");

	swi_kill_a: assert property (do_req && swi_kill |=> !swi_request_o)
		else $error("forced interrupt not suppressed");

	sequence s_bdm_taken;
		bdm_request_o && cpu_bdm_taken_i;
	endsequence

	final_state_a: assert property (forced_trigger_bit |=> final_state_o)
		else $error("trigger did not enter final state");

	forced_disarmed_a: assert property (idle && forced_trigger_bit_i && !armed_i
		|=> final_state_o)
		else $error("forced trigger ignored while disarmed");

	tag_trigger_a: assert property (idle && tag_fire && armed_i && !bdm_active_i
		|=> final_state_o)
		else $error("tagged opcode did not trigger");

	step_tag_a: assert property (idle && bdm_trace_cmd_i && tag_hit_i
		&& !forced_trigger_bit_i && !final_state_entry_i |=> !final_state_o)
		else $error("tag fired during single step");

	end_request_a: assert property (idle && forced_trigger_bit && !immediate_break_select_i
		&& trace_source_select_i && !trace_alignment_select_i && to_bdm
		|=> bdm_request_o && trace_stop_o)
		else $error("end alignment request missing");

	imm_stop_a: assert property (idle && forced_trigger_bit && immediate_break_select_i
		&& trace_source_select_i |=> trace_stop_o && !tracing_o)
		else $error("immediate break did not end tracing");

	trace_quiet_a: assert property (tracing_o && !trace_full_i
		|=> !swi_request_o && !bdm_request_o)
		else $error("request raised while tracing");

	swi_route_a: assert property ($rose(swi_request_o)
		|-> !$past(debug_target_i) || !$past(bdm_enabled_i))
		else $error("interrupt request with wrong routing");

	swi_defer_a: assert property (do_req && to_bdm && software_interrupt_instr_i
		|=> user_swi_deferred_o && bdm_request_o)
		else $error("user interrupt not deferred");

	reassert_a: assert property (q.st == dbrl_pkg::ST_HOLD && !monitor_serviced_i
		&& !bdm_active_i && bdm_enabled_i |=> bdm_request_o)
		else $error("unserviced breakpoint not re-asserted");

	resume_a: assert property (do_req && background_instr_i && idle
		&& (forced_trigger_bit_soft || tag_fire) |=> resume_after_background_instr_o)
		else $error("resume point not flagged");

	bdm_release_a: assert property (s_bdm_taken |=> !bdm_request_o)
		else $error("debug request kept after entry");

endmodule // dbrl_top

/* src/dbrl_pkg.sv */
// shared types and constants for the breakpoint request logic
package dbrl_pkg;

	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_TRACE = 2'b01,
		ST_REQ   = 2'b10,
		ST_HOLD  = 2'b11
	} dbrl_state_e_t;

	// ==========================================================
	// alignment encodings
	localparam logic ALIGN_END   = 1'h0;
	localparam logic ALIGN_BEGIN = 1'h1;

	// ==========================================================
	// reset values
	localparam logic RST_BIT = 1'h0;

	// ==========================================================
	// whole state of the top module
	typedef struct packed {
		dbrl_state_e_t st;
		logic          swi_req;
		logic          bdm_req;
		logic          final_state;
		logic          tracing;
		logic          trace_stop;
		logic          disarm;
		logic          src_soft;
		logic          swi_deferred;
		logic          resume_next;
	} dbrl_regs_t;

	localparam dbrl_regs_t REGS_RST = '{
		st:           ST_IDLE,
		swi_req:      RST_BIT,
		bdm_req:      RST_BIT,
		final_state:  RST_BIT,
		tracing:      RST_BIT,
		trace_stop:   RST_BIT,
		disarm:       RST_BIT,
		src_soft:     RST_BIT,
		swi_deferred: RST_BIT,
		resume_next:  RST_BIT
	};

	// tag tracker state
	typedef struct packed {
		logic pending;
	} dbrl_tag_t;

endpackage

/* src/dbrl_tag_tracker.sv */
// follows a tagged opcode until it reaches the execution stage
`timescale 1ns/1ns
module dbrl_tag_tracker (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic tag_set_i,
	input  wire logic tag_hit_i,
	input  wire logic block_i,
	output logic      fire_o
);

	dbrl_pkg::dbrl_tag_t q;
	dbrl_pkg::dbrl_tag_t next_q;

	always_comb begin
		next_q = q;
		if (block_i) begin
			next_q.pending = dbrl_pkg::RST_BIT;
		end else if (tag_set_i) begin
			next_q.pending = 1'h1;
		end else if (tag_hit_i) begin
			next_q.pending = dbrl_pkg::RST_BIT;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			q.pending <= dbrl_pkg::RST_BIT;
		end else begin
			q <= next_q;
		end
	end

	assign fire_o = q.pending & tag_hit_i & ~block_i;

endmodule // dbrl_tag_tracker

/* src/dbrl_route.sv */
// maps a breakpoint onto software interrupt or debug mode
`timescale 1ns/1ns
module dbrl_route (
	input  wire logic enable_i,
	input  wire logic target_i,
	input  wire logic bdm_enabled_i,
	input  wire logic bdm_active_i,
	output logic      to_swi_o,
	output logic      to_bdm_o
);

	logic none;

	always_comb begin
		none     = ~enable_i | (bdm_enabled_i & bdm_active_i);
		to_swi_o = ~none & (~target_i | ~bdm_enabled_i);
		to_bdm_o = ~none & target_i & bdm_enabled_i & ~bdm_active_i;
	end

endmodule // dbrl_route

/* verif/dbrl_cpu_model.sv */
// cpu core model that takes breakpoint requests and runs debug firmware
`timescale 1ns/1ns
module dbrl_cpu_model (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       swi_req_i,
	input  wire logic       bdm_req_i,
	input  wire logic [2:0] delay_i,
	input  wire logic       service_i,
	output logic            swi_taken_o,
	output logic            bdm_taken_o,
	output logic            serviced_o,
	output logic            bdm_active_o
);
	logic [2:0] wait_cnt;
	logic [2:0] act_cnt;

	// ==========================================================
	// request taking and firmware run
	always_ff @(posedge sys_clk_i) begin
		swi_taken_o <= 1'h0;
		bdm_taken_o <= 1'h0;
		serviced_o  <= 1'h0;
		if (rst_i) begin
			wait_cnt     <= 3'h0;
			act_cnt      <= 3'h0;
			bdm_active_o <= 1'h0;
		end else if (bdm_active_o) begin
			act_cnt <= act_cnt + 3'h1;
			if (act_cnt == 3'h4 && service_i)
				serviced_o <= 1'h1;
			if (act_cnt == 3'h5)
				bdm_active_o <= 1'h0;
		end else if ((swi_req_i || bdm_req_i) && !swi_taken_o && !bdm_taken_o) begin
			if (wait_cnt >= delay_i) begin
				wait_cnt <= 3'h0;
				if (bdm_req_i) begin
					bdm_taken_o  <= 1'h1;
					bdm_active_o <= 1'h1;
					act_cnt      <= 3'h0;
				end else
					swi_taken_o <= 1'h1;
			end else
				wait_cnt <= wait_cnt + 3'h1;
		end
	end
endmodule // dbrl_cpu_model

/* verif/tb.sv */
// self-checking testbench for the breakpoint request logic
`timescale 1ns/1ns
module tb;
	logic       sys_clk_i = 1'h0;
	logic       rst_i     = 1'h1;
	logic       arm = 1'h0, tsrc = 1'h0, imm = 1'h0, algn = 1'h0, en = 1'h0, tgt = 1'h0;
	logic       bden = 1'h1, stc = 1'h0, swin = 1'h0, bgin = 1'h0, svc = 1'h1;
	logic [4:0] pl  = 5'h0;
	logic [2:0] dly = 3'h0;
	logic       swi_q, bdm_q, fs_q, tr_q, ts_q, dis_q, def_q, res_q, sw_tk, bd_tk, srv, act;
	logic       p_swi = 1'h0;
	logic       p_bdm = 1'h0;
	logic       quick;
	logic [1:0] obs;
	logic [1:0] exp_q[$];
	int         num_errors = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         seed = 36;
	int         i;

	always #2 sys_clk_i = ~sys_clk_i;

	dbrl_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .armed_i(arm),
		.trace_source_select_i(tsrc), .immediate_break_select_i(imm),
		.trace_alignment_select_i(algn), .breakpoint_request_enable_i(en),
		.debug_target_i(tgt), .forced_trigger_bit_i(pl[1]), .final_state_entry_i(pl[0]),
		.tag_set_i(pl[3]), .tag_hit_i(pl[2]), .trace_full_i(pl[4]), .bdm_enabled_i(bden),
		.bdm_active_i(act), .bdm_trace_cmd_i(stc), .software_interrupt_instr_i(swin),
		.background_instr_i(bgin), .cpu_swi_taken_i(sw_tk), .cpu_bdm_taken_i(bd_tk),
		.monitor_serviced_i(srv), .swi_request_o(swi_q), .bdm_request_o(bdm_q),
		.final_state_o(fs_q), .tracing_o(tr_q), .trace_stop_o(ts_q), .disarm_o(dis_q),
		.user_swi_deferred_o(def_q), .resume_after_background_instr_o(res_q));

	dbrl_cpu_model cpu (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .swi_req_i(swi_q),
		.bdm_req_i(bdm_q), .delay_i(dly), .service_i(svc), .swi_taken_o(sw_tk),
		.bdm_taken_o(bd_tk), .serviced_o(srv), .bdm_active_o(act));

	// ==========================================================
	// helpers
	task check(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// pulse kinds: 0 final state, 1 forced, 2 tag hit, 3 tag set, 4 trace full
	task fire(input int k, input logic sw, input logic bg);
		@(posedge sys_clk_i);
		pl   <= 5'(1 << k);
		swin <= sw;
		bgin <= bg;
		@(posedge sys_clk_i);
		pl   <= 5'h0;
		swin <= 1'h0;
		bgin <= 1'h0;
	endtask

	task settle(input string name);
		int n;
		@(negedge sys_clk_i);
		for (n = 0; n < 200 && (swi_q | bdm_q | act | tr_q) !== 1'h0; n++)
			@(negedge sys_clk_i);
		repeat (3) @(negedge sys_clk_i);
		check(exp_q.size() == 0, "expected result missing");
		check(def_q === 1'h0 && res_q === 1'h0, "deferred or resume flag stuck");
		$display("test %s done", name);
	endtask

	// ==========================================================
	// result watcher
	always @(negedge sys_clk_i) begin
		cycles++;
		obs = 2'h0;
		if (swi_q === 1'h1 && p_swi !== 1'h1)
			obs = 2'h1;
		if (bdm_q === 1'h1 && p_bdm !== 1'h1)
			obs = 2'h2;
		if (dis_q === 1'h1)
			obs = 2'h3;
		p_swi <= swi_q;
		p_bdm <= bdm_q;
		if (obs !== 2'h0) begin
			if (exp_q.size() == 0)
				check(1'h0, "unexpected result");
			else
				check(exp_q.pop_front() === obs, "wrong result kind");
		end
		if (cycles > 20000) begin
			num_errors++;
			final_report();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		arm   <= 1'h1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk_i);
			tsrc <= i[3];
			imm  <= i[2];
			algn <= i[1];
			en   <= i[0];
			tgt  <= 1'($random(seed));
			dly  <= 3'($random(seed));
			@(posedge sys_clk_i);
			quick = imm | !algn | !tsrc;
			if (en)
				exp_q.push_back(tgt ? 2'h2 : 2'h1);
			else if (tsrc && !imm)
				exp_q.push_back(2'h3);
			fire(0, en & tgt & quick, 1'h0);
			@(negedge sys_clk_i);
			check(fs_q === 1'h1, "final state not entered");
			check(ts_q === (tsrc & quick), "trace stop wrong");
			if (en && tgt && quick)
				check(def_q === 1'h1, "user interrupt not deferred");
			if (!quick) begin
				check(tr_q === 1'h1, "begin trace not running");
				fire(1, 1'h0, 1'h0);
				fire(0, 1'h0, 1'h0);
				check(exp_q.size() == 1, "result before trace full");
				fire(4, 1'h0, 1'h0);
			end else
				check(tr_q === 1'h0, "tracing without begin alignment");
			settle("alignment");
		end
		@(posedge sys_clk_i);
		arm <= 1'h0;
		tgt <= 1'h0;
		fire(0, 1'h0, 1'h0);
		exp_q.push_back(2'h1);
		fire(1, 1'h0, 1'h0);
		settle("forced while disarmed");
		@(posedge sys_clk_i);
		arm <= 1'h1;
		tgt <= 1'h1;
		fire(3, 1'h0, 1'h0);
		exp_q.push_back(2'h2);
		fire(2, 1'h0, 1'h0);
		settle("tagged");
		@(posedge sys_clk_i);
		stc <= 1'h1;
		fire(3, 1'h0, 1'h0);
		fire(2, 1'h0, 1'h0);
		settle("tag in single step");
		@(posedge sys_clk_i);
		stc  <= 1'h0;
		bden <= 1'h0;
		exp_q.push_back(2'h1);
		fire(0, 1'h0, 1'h0);
		settle("debug disabled routing");
		@(posedge sys_clk_i);
		bden <= 1'h1;
		tgt  <= 1'h0;
		fire(1, 1'h0, 1'h1);
		settle("forced with background");
		@(posedge sys_clk_i);
		tgt <= 1'h1;
		exp_q.push_back(2'h2);
		fire(1, 1'h0, 1'h1);
		@(negedge sys_clk_i);
		check(res_q === 1'h1, "resume point not flagged");
		settle("resume after background");
		@(posedge sys_clk_i);
		svc <= 1'h0;
		exp_q.push_back(2'h2);
		exp_q.push_back(2'h2);
		fire(0, 1'h0, 1'h0);
		for (i = 0; i < 100 && act !== 1'h1; i++)
			@(negedge sys_clk_i);
		for (i = 0; i < 100 && act !== 1'h0; i++)
			@(negedge sys_clk_i);
		@(negedge sys_clk_i);
		check(bdm_q === 1'h1, "breakpoint not re-asserted");
		@(posedge sys_clk_i);
		svc <= 1'h1;
		settle("unserviced re-assert");
		final_report();
	end
endmodule // tb
